// >>> ppt_cfg.svh
`ifndef PPT_CFG_SVH
`define PPT_CFG_SVH
// ******************
// register offsets
// ******************
`define PPT_OFS_DATA 3'h0
`define PPT_OFS_STAT 3'h1
`define PPT_OFS_CTL  3'h2
`define PPT_OFS_EADR 3'h3
// ******************
// status bits
// ******************
`define PPT_ST_TMO 0
`define PPT_ST_ERR 3
`define PPT_ST_ONL 4
`define PPT_ST_PAP 5
`define PPT_ST_ACK 6
`define PPT_ST_BSY 7
// ******************
// control bits
// ******************
`define PPT_CT_STB  0
`define PPT_CT_LF   1
`define PPT_CT_INI  2
`define PPT_CT_SEL  3
`define PPT_CT_IRQ_ENABLE_BIT 4
`define PPT_CT_DIR  5
// ******************
// reset values
// ******************
`define PPT_DATA_RST 8'h00
`define PPT_CTL_RST  6'h00
`define PPT_EPP_RST  8'h00
// ******************
// timing
// ******************
`define PPT_CLK_NS  50
`define PPT_TMO_NS  10000
`define PPT_TMO_CYC (`PPT_TMO_NS / `PPT_CLK_NS)
`endif

// >>> ppt_pkg.sv
package ppt_pkg;
  // ******************
  // types
  // ******************
  typedef enum logic [1:0] {
    PPT_MODE_COMPAT,
    PPT_MODE_BIDIR,
    PPT_MODE_EPP
  } ppt_mode_t;

  typedef struct packed {
    logic       we;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ppt_req_t;

  // cable status inputs, raw pin levels
  typedef struct packed {
    logic busy;
    logic ack;
    logic paper_out;
    logic online;
    logic error;
  } ppt_pin_in_t;

  typedef enum logic [2:0] {
    PPT_IDLE,
    PPT_ARM,
    PPT_STB,
    PPT_HOLD
  } ppt_state_t;
endpackage

// >>> ppt_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "ppt_cfg.svh"
module ppt_port #(
  parameter int unsigned TMO_CYC = `PPT_TMO_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire ppt_pkg::ppt_mode_t   mode_i,
  input  wire logic                 tmo_policy_i,
  input  wire logic                 cyc_i,
  input  wire ppt_pkg::ppt_req_t    req_i,
  output logic                      ack_o,
  output logic [7:0]                rdata_o,
  input  wire ppt_pkg::ppt_pin_in_t pins_i,
  input  wire logic [7:0]           pd_i,
  output logic [7:0]                pd_o,
  output logic                      pd_oe_o,
  output logic                      data_latch_pulse_n_o,
  output logic                      line_feed_pin_n_o,
  output logic                      init_o,
  output logic                      select_in_pin_n_o,
  output logic                      irq_o
);
  localparam int TW = $clog2(TMO_CYC + 1);

  // ******************
  // pin synchronisers
  // ******************
  logic [12:0]          sync1;
  logic [12:0]          sync2;
  logic                 ack_q;
  ppt_pkg::ppt_pin_in_t pin_s;
  logic [7:0]           pd_s;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1 <= 13'h0000;
      sync2 <= 13'h0000;
      ack_q <= 1'b0;
    end else begin
      sync1 <= {pd_i, pins_i};
      sync2 <= sync1;
      ack_q <= sync2[3];
    end
  end

  assign pin_s = sync2[4:0];
  assign pd_s  = sync2[12:5];

  // ******************
  // register file and cycle control
  // ******************
  ppt_pkg::ppt_state_t state, next_state;
  logic [7:0]          data_reg, next_data_reg;
  logic [5:0]          ctl, next_ctl;
  logic [7:0]          epp_reg, next_epp_reg;
  logic                tmo_flag, next_tmo_flag;
  logic [TW-1:0]       tmo_cnt, next_tmo_cnt;
  logic                cyc_q;
  logic                st_rd, next_st_rd;
  logic                wr, next_wr;
  logic                adr, next_adr;
  logic                next_ack;
  logic [7:0]          next_rdata;
  logic                next_irq;
  logic [7:0]          next_pd;
  logic                next_pd_oe;
  logic                next_stb_n;
  logic                next_lf_n;
  logic                next_sel_n;
  logic                start;
  logic                epp;
  logic                compat;
  logic                win;
  logic                eact;
  logic                set_tmo;
  logic [7:0]          stat_byte;

  always_comb begin
    start  = cyc_i && !cyc_q;
    epp    = (mode_i == ppt_pkg::PPT_MODE_EPP);
    compat = (mode_i != ppt_pkg::PPT_MODE_BIDIR) && !epp;
    win    = (req_i.addr >= `PPT_OFS_EADR);
    eact   = (state == ppt_pkg::PPT_STB);
    set_tmo = 1'b0;
    stat_byte = 8'h00;
    stat_byte[`PPT_ST_TMO] = tmo_flag;
    stat_byte[`PPT_ST_ERR] = pin_s.error;
    stat_byte[`PPT_ST_ONL] = pin_s.online;
    stat_byte[`PPT_ST_PAP] = pin_s.paper_out;
    stat_byte[`PPT_ST_ACK] = pin_s.ack;
    stat_byte[`PPT_ST_BSY] = !pin_s.busy;
    next_state    = state;
    next_data_reg = data_reg;
    next_ctl      = ctl;
    next_epp_reg  = epp_reg;
    next_tmo_flag = tmo_flag;
    next_tmo_cnt  = tmo_cnt;
    next_st_rd    = st_rd;
    next_wr       = wr;
    next_adr      = adr;
    next_ack      = 1'b0;
    next_rdata    = rdata_o;
    next_irq      = ctl[`PPT_CT_IRQ_ENABLE_BIT] && pin_s.ack && !ack_q;
    case (state)
      ppt_pkg::PPT_IDLE: begin
        if (start && win && epp) begin
          // pcd high turns a write into a read on the cable
          next_wr      = req_i.we && !ctl[`PPT_CT_DIR];
          next_adr     = (req_i.addr == `PPT_OFS_EADR);
          next_epp_reg = req_i.we ? req_i.wdata : epp_reg;
          next_tmo_cnt = '0;
          next_state   = ppt_pkg::PPT_ARM;
        end else if (start) begin
          next_ack   = 1'b1;
          next_state = ppt_pkg::PPT_HOLD;
          if (req_i.we) begin
            case (req_i.addr)
              `PPT_OFS_DATA: next_data_reg = req_i.wdata;
              `PPT_OFS_STAT: begin
                if (!tmo_policy_i && req_i.wdata[`PPT_ST_TMO]) begin
                  next_tmo_flag = 1'b0;
                end
              end
              `PPT_OFS_CTL: next_ctl = req_i.wdata[5:0];
              default: next_ctl = ctl;
            endcase
          end else begin
            case (req_i.addr)
              `PPT_OFS_DATA: next_rdata = pd_s;
              `PPT_OFS_STAT: begin
                next_rdata = stat_byte;
                next_st_rd = 1'b1;
              end
              `PPT_OFS_CTL: next_rdata = {2'b00, ctl};
              default: next_rdata = 8'h00;
            endcase
          end
        end
      end
      ppt_pkg::PPT_ARM: begin
        // wait for the peripheral's wait line (busy) to be low first
        next_tmo_cnt = tmo_cnt + TW'(1);
        if (tmo_cnt == TW'(TMO_CYC)) begin
          set_tmo = 1'b1;
        end else if (!pin_s.busy) begin
          next_state = ppt_pkg::PPT_STB;
        end
      end
      ppt_pkg::PPT_STB: begin
        next_tmo_cnt = tmo_cnt + TW'(1);
        if (tmo_cnt == TW'(TMO_CYC)) begin
          set_tmo = 1'b1;
        end else if (pin_s.busy) begin
          next_ack   = 1'b1;
          next_state = ppt_pkg::PPT_HOLD;
          if (!wr) begin
            next_epp_reg = pd_s;
            next_rdata   = pd_s;
          end
        end
      end
      ppt_pkg::PPT_HOLD: begin
        if (!cyc_i) begin
          next_state = ppt_pkg::PPT_IDLE;
          next_st_rd = 1'b0;
          if (st_rd && tmo_policy_i) begin
            next_tmo_flag = 1'b0;
          end
        end
      end
      default: next_state = ppt_pkg::PPT_IDLE;
    endcase
    if (set_tmo) begin
      // abort: strobes drop, host is released with stale data
      next_ack      = 1'b1;
      next_state    = ppt_pkg::PPT_HOLD;
      next_rdata    = epp_reg;
    end
    if (set_tmo) begin
      next_tmo_flag = 1'b1;
    end
    // ******************
    // cable pins
    // ******************
    next_pd    = (eact && wr) ? epp_reg : data_reg;
    next_pd_oe = eact ? wr : (compat || !ctl[`PPT_CT_DIR]);
    next_stb_n = eact ? !wr : !ctl[`PPT_CT_STB];
    next_lf_n  = (eact && !adr) ? 1'b0 : !ctl[`PPT_CT_LF];
    next_sel_n = (eact && adr) ? 1'b0 : !ctl[`PPT_CT_SEL];
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state                <= ppt_pkg::PPT_IDLE;
      data_reg             <= `PPT_DATA_RST;
      ctl                  <= `PPT_CTL_RST;
      epp_reg              <= `PPT_EPP_RST;
      tmo_flag             <= 1'b0;
      tmo_cnt              <= '0;
      cyc_q                <= 1'b0;
      st_rd                <= 1'b0;
      wr                   <= 1'b0;
      adr                  <= 1'b0;
      ack_o                <= 1'b0;
      rdata_o              <= 8'h00;
      irq_o                <= 1'b0;
      pd_o                 <= `PPT_DATA_RST;
      pd_oe_o              <= 1'b1;
      data_latch_pulse_n_o <= 1'b1;
      line_feed_pin_n_o    <= 1'b1;
      init_o               <= 1'b0;
      select_in_pin_n_o    <= 1'b1;
    end else begin
      state                <= next_state;
      data_reg             <= next_data_reg;
      ctl                  <= next_ctl;
      epp_reg              <= next_epp_reg;
      tmo_flag             <= next_tmo_flag;
      tmo_cnt              <= next_tmo_cnt;
      cyc_q                <= cyc_i;
      st_rd                <= next_st_rd;
      wr                   <= next_wr;
      adr                  <= next_adr;
      ack_o                <= next_ack;
      rdata_o              <= next_rdata;
      irq_o                <= next_irq;
      pd_o                 <= next_pd;
      pd_oe_o              <= next_pd_oe;
      data_latch_pulse_n_o <= next_stb_n;
      line_feed_pin_n_o    <= next_lf_n;
      init_o               <= ctl[`PPT_CT_INI];
      select_in_pin_n_o    <= next_sel_n;
    end
  end

  // ******************
  // checks
  // ******************
  property p_data_drive;
    @(posedge clk_i) disable iff (!rst_n_i)
    (start && state == ppt_pkg::PPT_IDLE && req_i.we && req_i.addr == `PPT_OFS_DATA
      && compat) |-> ##2 (pd_o == $past(req_i.wdata, 2));
  endproperty
  a_data_drive: assert property (p_data_drive) else $error("data pins miss write");

  property p_stat_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
    (start && state == ppt_pkg::PPT_IDLE && !req_i.we && req_i.addr == `PPT_OFS_STAT)
      |=> ack_o ##1 $stable(rdata_o);
  endproperty
  a_stat_hold: assert property (p_stat_hold) else $error("status not held");

  property p_stat_zero;
    @(posedge clk_i) disable iff (!rst_n_i)
    (ack_o && st_rd) |-> (rdata_o[2:1] == 2'b00);
  endproperty
  a_stat_zero: assert property (p_stat_zero) else $error("status bits 1,2 set");

  property p_busy_inv;
    @(posedge clk_i) disable iff (!rst_n_i)
    (start && state == ppt_pkg::PPT_IDLE && !req_i.we && req_i.addr == `PPT_OFS_STAT)
      |=> (rdata_o[7] == !$past(pin_s.busy));
  endproperty
  a_busy_inv: assert property (p_busy_inv) else $error("busy bit not inverted");

  property p_tmo_set;
    @(posedge clk_i) disable iff (!rst_n_i)
    (state inside {ppt_pkg::PPT_ARM, ppt_pkg::PPT_STB} && tmo_cnt == TW'(TMO_CYC))
      |=> (tmo_flag && ack_o && state == ppt_pkg::PPT_HOLD);
  endproperty
  a_tmo_set: assert property (p_tmo_set) else $error("timeout not taken");

  property p_tmo_wclr;
    @(posedge clk_i) disable iff (!rst_n_i)
    (start && state == ppt_pkg::PPT_IDLE && req_i.we && req_i.addr == `PPT_OFS_STAT
      && !tmo_policy_i) |=> (tmo_flag == ($past(tmo_flag) && !$past(req_i.wdata[0])));
  endproperty
  a_tmo_wclr: assert property (p_tmo_wclr) else $error("timeout write clear");

  property p_ctl_top;
    @(posedge clk_i) disable iff (!rst_n_i)
    (start && state == ppt_pkg::PPT_IDLE && !req_i.we && req_i.addr == `PPT_OFS_CTL)
      |=> (rdata_o[7:6] == 2'b00);
  endproperty
  a_ctl_top: assert property (p_ctl_top) else $error("control top bits set");

  property p_stb_pin;
    @(posedge clk_i) disable iff (!rst_n_i)
    (state != ppt_pkg::PPT_STB) |=> (data_latch_pulse_n_o == !$past(ctl[`PPT_CT_STB]));
  endproperty
  a_stb_pin: assert property (p_stb_pin) else $error("strobe pin wrong");

  property p_irq_off;
    @(posedge clk_i) disable iff (!rst_n_i)
    !ctl[`PPT_CT_IRQ_ENABLE_BIT] |=> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");

  property p_compat_out;
    @(posedge clk_i) disable iff (!rst_n_i)
    (compat && state != ppt_pkg::PPT_STB) |=> pd_oe_o;
  endproperty
  a_compat_out: assert property (p_compat_out) else $error("pins not driven");

  property p_no_side;
    @(posedge clk_i) disable iff (!rst_n_i)
    (start && state == ppt_pkg::PPT_IDLE && !epp && win && !req_i.we)
      |=> (rdata_o == 8'h00 && tmo_flag == $past(tmo_flag) && state == ppt_pkg::PPT_HOLD);
  endproperty
  a_no_side: assert property (p_no_side) else $error("side effect on read");
endmodule
`default_nettype wire

// >>> ppt_peer_model.sv
`timescale 1ns/10ps
`default_nettype none
// ******************
// cable peripheral
// ******************
module ppt_peer_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       en_i,
  input  wire logic [3:0] dly_i,
  input  wire logic [7:0] rdv_i,
  input  wire logic       dstb_n_i,
  input  wire logic       astb_n_i,
  input  wire logic       oe_i,
  input  wire logic [7:0] pd_i,
  output logic            wait_o,
  output logic [7:0]      pd_o,
  output logic [7:0]      cap_o
);
  logic       stb;
  logic [3:0] cnt;
  // either strobe pin low opens a transfer
  assign stb = en_i && !(dstb_n_i && astb_n_i);
  // released bus shows the inverse, never a stale copy
  assign pd_o = (stb && !oe_i) ? rdv_i : ~rdv_i;
  // dly 0 never answers, so the device must time out
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt    <= 4'h0;
      wait_o <= 1'b0;
      cap_o  <= 8'h00;
    end else if (!stb) begin
      cnt    <= 4'h0;
      wait_o <= 1'b0;
    end else begin
      if (oe_i) cap_o <= pd_i;
      if (dly_i != 4'h0 && cnt < dly_i) cnt <= cnt + 4'h1;
      if (dly_i != 4'h0 && cnt == dly_i) wait_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> parallel_port_spp_epp_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module parallel_port_spp_epp_regs_tb_top;
  logic                 clk_i   = 1'b0;
  logic                 rst_n_i = 1'b0;
  logic                 cyc     = 1'b0;
  logic                 pol     = 1'b0;
  logic                 me      = 1'b0;
  ppt_pkg::ppt_mode_t   mode    = ppt_pkg::PPT_MODE_COMPAT;
  ppt_pkg::ppt_req_t    req     = '0;
  ppt_pkg::ppt_pin_in_t pins;
  logic [4:0]           sp      = 5'h00;
  logic [3:0]           dly     = 4'h0;
  logic [7:0]           rdv     = 8'h96;
  logic [7:0]           rd;
  wire  logic           ack, oe, stb_n, lf_n, ini, sel_n, irq, m_wait;
  wire  logic [7:0]     rdata, pd_o, m_pd, cap, pdw;
  int                   fails = 0;
  int                   tests_run = 0;
  int                   n;
  assign pins = {me ? m_wait : sp[4], sp[3:0]};
  assign pdw  = oe ? pd_o : m_pd;
  // short timeout keeps the run brief
  ppt_port #(.TMO_CYC(16)) DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .mode_i(mode), .tmo_policy_i(pol),
    .cyc_i(cyc), .req_i(req), .ack_o(ack), .rdata_o(rdata), .pins_i(pins),
    .pd_i(pdw), .pd_o(pd_o), .pd_oe_o(oe), .data_latch_pulse_n_o(stb_n),
    .line_feed_pin_n_o(lf_n), .init_o(ini), .select_in_pin_n_o(sel_n),
    .irq_o(irq));
  ppt_peer_model PEER (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(me), .dly_i(dly), .rdv_i(rdv),
    .dstb_n_i(lf_n), .astb_n_i(sel_n), .oe_i(oe), .pd_i(pd_o),
    .wait_o(m_wait), .pd_o(m_pd), .cap_o(cap));
  // ******************
  // helpers
  // ******************
  task chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task results;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task wt(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  // one host cycle; ack sampled mid-cycle, dropped on the next edge
  task acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    req <= '{we: w, addr: a, wdata: d};
    for (i = 0; i < 40; i++) begin
      @(negedge clk_i);
      if (ack === 1'b1) break;
    end
    if (i == 40) begin
      fails++;
      results;
    end
    rd = rdata;
    @(posedge clk_i);
    cyc <= 1'b0;
  endtask
  task irqs;
    n = 0;
    wt(1);
    sp <= 5'h00;
    wt(3);
    sp <= 5'h08;
    repeat (8) begin
      @(negedge clk_i);
      if (irq === 1'b1) n++;
    end
    wt(1);
  endtask
  // ******************
  // sequence
  // ******************
  initial forever #25 clk_i = ~clk_i;
  initial begin
    wt(8);
    rst_n_i <= 1'b1;
    acc(0, 3'h0, 8'h00);
    chk("data", rd, 8'h00);
    chk("pins", {4'h0, stb_n, lf_n, ini, sel_n}, 8'h0d);
    acc(0, 3'h2, 8'h00);
    chk("ctl", rd, 8'h00);
    acc(1, 3'h0, 8'ha5);
    wt(1);
    chk("pd", pd_o, 8'ha5);
    acc(0, 3'h0, 8'h00);
    chk("rdback", rd, 8'ha5);
    acc(1, 3'h2, 8'hff);
    acc(0, 3'h2, 8'h00);
    chk("ctl", rd, 8'h3f);
    chk("pins", {4'h0, stb_n, lf_n, ini, sel_n}, 8'h02);
    chk("oe", {7'h00, oe}, 8'h01);
    mode <= ppt_pkg::PPT_MODE_BIDIR;
    wt(2);
    chk("oe", {7'h00, oe}, 8'h00);
    mode <= ppt_pkg::PPT_MODE_COMPAT;
    acc(1, 3'h2, 8'h05);
    wt(1);
    chk("pins", {4'h0, stb_n, lf_n, ini, sel_n}, 8'h07);
    // one status pin high at a time, last pass all low
    for (int k = 0; k < 6; k++) begin
      sp <= 5'h01 << k;
      wt(3);
      acc(0, 3'h1, 8'h00);
      chk("status", rd, {~sp[4], sp[3:0], 3'b000});
    end
    acc(1, 3'h2, 8'h14);
    irqs;
    chk("irq", 8'(n), 8'h01);
    acc(1, 3'h2, 8'h04);
    irqs;
    chk("irq", 8'(n), 8'h00);
    mode <= ppt_pkg::PPT_MODE_EPP;
    me   <= 1'b1;
    dly  <= 4'h2;
    acc(1, 3'h3, 8'h5a);
    chk("cap", cap, 8'h5a);
    acc(1, 3'h4, 8'hc3);
    chk("cap", cap, 8'hc3);
    acc(0, 3'h7, 8'h00);
    chk("win", rd, 8'h96);
    acc(0, 3'h1, 8'h00);
    chk("tmo", {7'h0, rd[0]}, 8'h00);
    dly <= 4'h0;
    acc(1, 3'h5, 8'h11);
    acc(0, 3'h1, 8'h00);
    chk("tmo", {7'h0, rd[0]}, 8'h01);
    acc(1, 3'h1, 8'h00);
    acc(0, 3'h1, 8'h00);
    chk("tmo", {7'h0, rd[0]}, 8'h01);
    mode <= ppt_pkg::PPT_MODE_COMPAT;
    acc(0, 3'h6, 8'h00);
    chk("unavail", rd, 8'h00);
    acc(1, 3'h3, 8'h77);
    wt(1);
    chk("pd", pd_o, 8'ha5);
    mode <= ppt_pkg::PPT_MODE_EPP;
    acc(0, 3'h1, 8'h00);
    chk("tmo", {7'h0, rd[0]}, 8'h01);
    acc(1, 3'h1, 8'h01);
    acc(0, 3'h1, 8'h00);
    chk("tmo", {7'h0, rd[0]}, 8'h00);
    pol <= 1'b1;
    acc(1, 3'h4, 8'h22);
    acc(0, 3'h1, 8'h00);
    chk("tmo", {7'h0, rd[0]}, 8'h01);
    acc(0, 3'h1, 8'h00);
    chk("tmo", {7'h0, rd[0]}, 8'h00);
    results;
  end
endmodule
`default_nettype wire
